/* File: src/dmt_half.sv */
/*
 One 8-bit counter half of the timer: load, clear and increment.
 Resolves priority itself: load beats clear, which beats tick.
*/
`timescale 1ns/10ps
`default_nettype none
module dmt_half
   import dmt_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       tick,
   input  wire logic       clear,
   input  wire logic       load,
   input  wire logic [7:0] load_value,
   output var  logic [7:0] count
);

   // a software load beats a match clear, which beats counting
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= DMT_CNT_RST;
      end else if (load) begin
         count <= load_value;
      end else if (clear) begin
         count <= DMT_CNT_RST;
      end else if (tick) begin
         count <= count + 8'h01;
      end
   end

endmodule // dmt_half
`default_nettype wire

/* File: src/dmt_pkg.sv */
/*
 Constants for the dual-mode timer control block: register offsets on the
 APB port, field positions, values after reset and prescaler tap masks.
 Assumes a 200 MHz system clock that also drives the APB port.
*/
// Behaviour
// - write-only 8-bit control register, resets to zero
// - control bit 7 sets high toggle level
// - bit 6 low: high counts low overflows
// - bit 6 high: bits 5:4 pick high divider
// - control bit 3 sets low toggle level
// - bit 2 low: low counts chosen event edges
// - bit 2 high: bits 1:0 pick low divider
// - readable/writable 8-bit status register, resets zero
// - high rollover sets high overflow flag
// - flag clears by writing 0 after reading 1
// - writing 1 never sets a flag
// - high compare match sets high match flag
// - status bit 5 enables high overflow interrupt
// - bit 4 clears counter on high match
// - low rollover sets low overflow flag
// - low compare match sets low match flag
// - status bit 1 enables low overflow interrupt
// - bit 0 clears low counter on low match in 8-bit mode
// - 16-bit rollover sets high overflow flag
// - toggle outputs invert on each own match
package dmt_pkg;

   // byte addresses on the APB port
   localparam logic [7:0] DMT_CTRL_OFF = 8'h00;
   localparam logic [7:0] DMT_STAT_OFF = 8'h04;
   localparam logic [7:0] DMT_HCNT_OFF = 8'h08;
   localparam logic [7:0] DMT_LCNT_OFF = 8'h0C;
   localparam logic [7:0] DMT_HCMP_OFF = 8'h10;
   localparam logic [7:0] DMT_LCMP_OFF = 8'h14;
   localparam logic [7:0] DMT_AUX_OFF  = 8'h18;

   localparam logic [7:0] DMT_CTRL_RST = 8'h00;
   localparam logic [7:0] DMT_STAT_RST = 8'h00;
   localparam logic [7:0] DMT_CNT_RST  = 8'h00;
   localparam logic [7:0] DMT_CMP_RST  = 8'hFF;
   localparam logic [7:0] DMT_AUX_RST  = 8'h00;
   localparam logic [7:0] DMT_CNT_MAX  = 8'hFF;

   // control fields
   localparam int DMT_CTRL_HLVL    = 7;
   localparam int DMT_CTRL_HMODE8  = 6;
   localparam int DMT_CTRL_HSEL_HI = 5;
   localparam int DMT_CTRL_HSEL_LO = 4;
   localparam int DMT_CTRL_LLVL    = 3;
   localparam int DMT_CTRL_LINT    = 2;
   localparam int DMT_CTRL_LSEL_HI = 1;
   localparam int DMT_CTRL_LSEL_LO = 0;

   // status fields
   localparam int DMT_STAT_HOVF  = 7;
   localparam int DMT_STAT_HMAT  = 6;
   localparam int DMT_STAT_HOVIE = 5;
   localparam int DMT_STAT_HCLR  = 4;
   localparam int DMT_STAT_LOVF  = 3;
   localparam int DMT_STAT_LMAT  = 2;
   localparam int DMT_STAT_LOVIE = 1;
   localparam int DMT_STAT_LCLR  = 0;
   localparam logic [7:0] DMT_FLAG_MASK = 8'hCC;

   // auxiliary fields: event edge and pin function
   localparam int DMT_AUX_EDGE  = 0;
   localparam int DMT_AUX_PINFN = 1;

   // prescaler taps: a tick when all masked bits are one
   localparam int         DMT_PRE_W      = 5;
   localparam logic [4:0] DMT_PRE_RST    = 5'h00;
   localparam logic [4:0] DMT_DIV32_MASK = 5'h1F;
   localparam logic [4:0] DMT_DIV16_MASK = 5'h0F;
   localparam logic [4:0] DMT_DIV4_MASK  = 5'h03;
   localparam logic [4:0] DMT_DIV2_MASK  = 5'h01;

   typedef enum logic {DMT_IDLE, DMT_ANSWER} dmt_apb_state_t;

endpackage

/* File: src/dmt_top.sv */
/*
 Dual-mode timer: control and status registers on an APB slave, prescaler,
 event input edge detection, two cascadable 8-bit counters, compare match,
 overflow flags, toggle outputs and overflow request lines.
 Assumes APB signals and the event pin are synchronous to CLOCK, except
 that the event pin is still passed through a two-stage synchroniser.
*/
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module dmt_top
   import dmt_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        ARST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output var  logic [31:0] PRDATA,
   output var  logic        PREADY,
   output var  logic        PSLVERR,
   input  wire logic        EVENT_INPUT_PIN,
   output var  logic        HIGH_TOGGLE_OUT,
   output var  logic        LOW_TOGGLE_OUT,
   output var  logic        HIGH_OVF_IRQ,
   output var  logic        LOW_OVF_IRQ
);

   dmt_apb_state_t   state;
   logic [7:0]       ctrl;
   logic [7:0]       stat;
   logic [7:0]       aux;
   logic [7:0]       hcmp;
   logic [7:0]       lcmp;
   logic [7:0]       hcnt;
   logic [7:0]       lcnt;
   logic [7:0]       armed;
   logic [DMT_PRE_W-1:0] pre;
   logic             ev_s1;
   logic             ev_s2;
   logic             ev_prev;
   logic             ev_lvl;
   logic             ev_edge;
   logic             access;
   logic             done;
   logic             wr_done;
   logic             rd_done;
   logic             wr_ctrl;
   logic             wr_stat;
   logic             wr_hcnt;
   logic             wr_lcnt;
   logic             wr_hcmp;
   logic             wr_lcmp;
   logic             wr_aux;
   logic             rd_stat;
   logic             addr_ok;
   logic [7:0]       rd_value;
   logic             mode16;
   logic             hi_int_tick;
   logic             lo_int_tick;
   logic             lo_tick;
   logic             hi_tick;
   logic             lo_match;
   logic             full_match;
   logic             hi_match;
   logic             hi_clr;
   logic             lo_clr;
   logic             hi_ovf;
   logic             lo_ovf;
   logic [7:0]       flag_set;
   logic [7:0]       flag_clr;
   logic [7:0]       next_stat;

   function automatic logic [4:0] sel_mask(input logic [1:0] code);
      case (code)
         2'b00:   sel_mask = DMT_DIV32_MASK;
         2'b01:   sel_mask = DMT_DIV16_MASK;
         2'b10:   sel_mask = DMT_DIV4_MASK;
         default: sel_mask = DMT_DIV2_MASK;
      endcase
   endfunction

   // APB decode; a transfer completes when the access phase sees PREADY
   assign access  = PSEL & PENABLE;
   assign done    = access & PREADY;
   assign wr_done = done & PWRITE;
   assign rd_done = done & ~PWRITE;
   assign wr_ctrl = wr_done & (PADDR == DMT_CTRL_OFF);
   assign wr_stat = wr_done & (PADDR == DMT_STAT_OFF);
   assign wr_hcnt = wr_done & (PADDR == DMT_HCNT_OFF);
   assign wr_lcnt = wr_done & (PADDR == DMT_LCNT_OFF);
   assign wr_hcmp = wr_done & (PADDR == DMT_HCMP_OFF);
   assign wr_lcmp = wr_done & (PADDR == DMT_LCMP_OFF);
   assign wr_aux  = wr_done & (PADDR == DMT_AUX_OFF);
   assign rd_stat = rd_done & (PADDR == DMT_STAT_OFF);

   always_comb begin
      addr_ok  = 1'b1;
      rd_value = 8'h00;
      case (PADDR)
         DMT_CTRL_OFF: rd_value = 8'h00;   // write-only, reads zero
         DMT_STAT_OFF: rd_value = stat;
         DMT_HCNT_OFF: rd_value = hcnt;
         DMT_LCNT_OFF: rd_value = lcnt;
         DMT_HCMP_OFF: rd_value = hcmp;
         DMT_LCMP_OFF: rd_value = lcmp;
         DMT_AUX_OFF:  rd_value = aux;
         default:      addr_ok  = 1'b0;
      endcase
   end

   // one wait state: answer on the second access cycle
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         state   <= DMT_IDLE;
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         case (state)
            DMT_IDLE: begin
               if (access) begin
                  state   <= DMT_ANSWER;
                  PREADY  <= 1'b1;
                  PRDATA  <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_value};
                  PSLVERR <= ~addr_ok;
               end
            end
            DMT_ANSWER: begin
               state   <= DMT_IDLE;
               PREADY  <= 1'b0;
               PSLVERR <= 1'b0;
            end
            default: begin
               state   <= DMT_IDLE;
               PREADY  <= 1'b0;
               PSLVERR <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl <= DMT_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl <= PWDATA[7:0];
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         aux  <= DMT_AUX_RST;
         hcmp <= DMT_CMP_RST;
         lcmp <= DMT_CMP_RST;
      end else begin
         if (wr_aux) begin
            aux <= PWDATA[7:0];
         end
         if (wr_hcmp) begin
            hcmp <= PWDATA[7:0];
         end
         if (wr_lcmp) begin
            lcmp <= PWDATA[7:0];
         end
      end
   end

   // free-running prescaler shared by both halves
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         pre <= DMT_PRE_RST;
      end else begin
         pre <= pre + 5'h01;
      end
   end

   assign hi_int_tick = (pre & sel_mask(ctrl[DMT_CTRL_HSEL_HI:DMT_CTRL_HSEL_LO]))
                        == sel_mask(ctrl[DMT_CTRL_HSEL_HI:DMT_CTRL_HSEL_LO]);
   assign lo_int_tick = (pre & sel_mask(ctrl[DMT_CTRL_LSEL_HI:DMT_CTRL_LSEL_LO]))
                        == sel_mask(ctrl[DMT_CTRL_LSEL_HI:DMT_CTRL_LSEL_LO]);

   // pin not in event function reads high, so switching it while low looks
   // like an edge; software is expected to avoid that
   assign ev_lvl = aux[DMT_AUX_PINFN] ? ev_s2 : 1'b1;

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         ev_s1   <= 1'b1;
         ev_s2   <= 1'b1;
         ev_prev <= 1'b1;
      end else begin
         ev_s1   <= EVENT_INPUT_PIN;
         ev_s2   <= ev_s1;
         ev_prev <= ev_lvl;
      end
   end

   assign ev_edge = aux[DMT_AUX_EDGE] ? (ev_lvl & ~ev_prev)
                                      : (~ev_lvl & ev_prev);

   assign mode16  = ~ctrl[DMT_CTRL_HMODE8];
   assign lo_tick = ctrl[DMT_CTRL_LINT] ? lo_int_tick : ev_edge;

   // match fires as the counter leaves the matching value; a compare write
   // in the same cycle suppresses it
   assign lo_match   = lo_tick & (lcnt == lcmp) & ~wr_lcmp;
   assign full_match = mode16 & lo_tick & ({hcnt, lcnt} == {hcmp, lcmp})
                       & ~wr_hcmp & ~wr_lcmp;
   assign lo_clr     = mode16 ? (full_match & stat[DMT_STAT_HCLR])
                              : (lo_match & stat[DMT_STAT_LCLR]);
   assign hi_tick    = mode16 ? (lo_tick & (lcnt == DMT_CNT_MAX) & ~lo_clr)
                              : hi_int_tick;
   assign hi_match   = mode16 ? full_match
                              : (hi_tick & (hcnt == hcmp) & ~wr_hcmp);
   assign hi_clr     = hi_match & stat[DMT_STAT_HCLR];
   assign lo_ovf     = lo_tick & (lcnt == DMT_CNT_MAX) & ~lo_clr;
   // in 16-bit mode hi_tick implies low at its maximum: a 16-bit rollover
   assign hi_ovf     = hi_tick & (hcnt == DMT_CNT_MAX) & ~hi_clr;

   dmt_half u_high (
      .clk        (CLOCK),
      .arst_n     (ARST_N),
      .tick       (hi_tick),
      .clear      (hi_clr),
      .load       (wr_hcnt),
      .load_value (PWDATA[7:0]),
      .count      (hcnt)
   );

   dmt_half u_low (
      .clk        (CLOCK),
      .arst_n     (ARST_N),
      .tick       (lo_tick),
      .clear      (lo_clr),
      .load       (wr_lcnt),
      .load_value (PWDATA[7:0]),
      .count      (lcnt)
   );

   // hardware set wins over a software clear in the same cycle
   always_comb begin
      flag_set = 8'h00;
      flag_set[DMT_STAT_HOVF] = hi_ovf;
      flag_set[DMT_STAT_HMAT] = hi_match;
      flag_set[DMT_STAT_LOVF] = lo_ovf;
      flag_set[DMT_STAT_LMAT] = lo_match;
      flag_clr  = wr_stat ? (~PWDATA[7:0] & armed & DMT_FLAG_MASK) : 8'h00;
      // written ones on flag bits are dropped
      next_stat = (wr_stat ? (PWDATA[7:0] & ~DMT_FLAG_MASK) : (stat & ~DMT_FLAG_MASK))
                  | flag_set | (stat & DMT_FLAG_MASK & ~flag_clr);
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         stat <= DMT_STAT_RST;
      end else begin
         stat <= next_stat;
      end
   end

   // remembers which flags software has seen as one
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         armed <= 8'h00;
      end else if (rd_stat) begin
         armed <= PRDATA[7:0] & DMT_FLAG_MASK;
      end else if (wr_stat) begin
         armed <= armed & PWDATA[7:0];
      end
   end

   // a control write wins over a coincident match toggle
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         HIGH_TOGGLE_OUT <= 1'b0;
         LOW_TOGGLE_OUT  <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            HIGH_TOGGLE_OUT <= PWDATA[DMT_CTRL_HLVL];
         end else if (hi_match) begin
            HIGH_TOGGLE_OUT <= ~HIGH_TOGGLE_OUT;
         end
         if (wr_ctrl) begin
            LOW_TOGGLE_OUT <= PWDATA[DMT_CTRL_LLVL];
         end else if (lo_match) begin
            LOW_TOGGLE_OUT <= ~LOW_TOGGLE_OUT;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         HIGH_OVF_IRQ <= 1'b0;
         LOW_OVF_IRQ  <= 1'b0;
      end else begin
         HIGH_OVF_IRQ <= stat[DMT_STAT_HOVF] & stat[DMT_STAT_HOVIE];
         LOW_OVF_IRQ  <= stat[DMT_STAT_LOVF] & stat[DMT_STAT_LOVIE];
      end
   end

   a_ctrl_write_load: assert property (
      @(posedge CLOCK) disable iff (!ARST_N)
      wr_ctrl |=> (ctrl == $past(PWDATA[7:0])) && HIGH_TOGGLE_OUT == $past(PWDATA[7]))
      else $error("control write not loaded");

   a_ctrl_reads_zero: assert property (
      @(posedge CLOCK) disable iff (!ARST_N)
      (state == DMT_IDLE) && access && !PWRITE && (PADDR == DMT_CTRL_OFF)
      |=> PREADY && (PRDATA == 32'h0000_0000))
      else $error("control register not write-only");

   a_low_level_write: assert property (
      @(posedge CLOCK) disable iff (!ARST_N)
      wr_ctrl |=> LOW_TOGGLE_OUT == $past(PWDATA[DMT_CTRL_LLVL]))
      else $error("low toggle level not applied");

   a_high_div32_tap: assert property (
      @(posedge CLOCK) disable iff (!ARST_N)
      ctrl[DMT_CTRL_HMODE8] && (ctrl[DMT_CTRL_HSEL_HI:DMT_CTRL_HSEL_LO] == 2'b00)
      && hi_tick |-> (pre == DMT_DIV32_MASK))
      else $error("high divide by 32 wrong tap");

   a_low_div2_rate: assert property (
      @(posedge CLOCK) disable iff (!ARST_N)
      ctrl[DMT_CTRL_LINT] && (ctrl[DMT_CTRL_LSEL_HI:DMT_CTRL_LSEL_LO] == 2'b11) && lo_tick
      && !wr_ctrl ##1 !wr_ctrl |-> !lo_tick ##1 lo_tick)
      else $error("low divide by 2 wrong rate");

   a_cascade_clock: assert property (
      @(posedge CLOCK) disable iff (!ARST_N)
      mode16 && hi_tick |-> lo_tick && (lcnt == DMT_CNT_MAX))
      else $error("high counted without low overflow");

   a_low_count_step: assert property (
      @(posedge CLOCK) disable iff (!ARST_N)
      lo_tick && !lo_clr && !wr_lcnt |=> lcnt == $past(lcnt) + 8'h01)
      else $error("low counter did not step");

   a_flag_clear_armed: assert property (
      @(posedge CLOCK) disable iff (!ARST_N)
      wr_stat && !PWDATA[DMT_STAT_HOVF] && armed[DMT_STAT_HOVF] && !hi_ovf
      |=> !stat[DMT_STAT_HOVF])
      else $error("armed flag not cleared");

   a_flag_no_sw_set: assert property (
      @(posedge CLOCK) disable iff (!ARST_N)
      wr_stat && PWDATA[DMT_STAT_LMAT] && !stat[DMT_STAT_LMAT] && !lo_match
      |=> !stat[DMT_STAT_LMAT])
      else $error("software set a match flag");

   a_overflow_flag_set: assert property (
      @(posedge CLOCK) disable iff (!ARST_N)
      hi_ovf |=> stat[DMT_STAT_HOVF] ##1 HIGH_OVF_IRQ == stat[DMT_STAT_HOVIE] || !$stable(stat))
      else $error("high overflow flag missed");

   a_match_clears_high: assert property (
      @(posedge CLOCK) disable iff (!ARST_N)
      hi_match && stat[DMT_STAT_HCLR] && !wr_hcnt |=> hcnt == DMT_CNT_RST)
      else $error("high counter not cleared on match");

   a_low_toggle_match: assert property (
      @(posedge CLOCK) disable iff (!ARST_N)
      lo_match && !wr_ctrl |=> LOW_TOGGLE_OUT != $past(LOW_TOGGLE_OUT))
      else $error("low toggle did not invert");

endmodule // dmt_top
`default_nettype wire

/* File: verif/dmt_top_bench.sv */
/*
 Self-checking bench for the dual-mode timer: APB master, event pin
 and reset all driven here, no partner model.
 Assumes the one-wait-state slave and the offsets of dmt_pkg.
*/
`timescale 1ns/10ps
`default_nettype none
module dmt_top_bench
   import dmt_pkg::*;
();
   logic        clk;
   logic        arst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic        pin;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        hi_out;
   logic        lo_out;
   logic        hi_irq;
   logic        lo_irq;
   logic [7:0]  rv;
   logic        re;
   int          n_fail = 0;
   int          tests_run = 0;
   int          cycles = 0;

   dmt_top dut (
      .CLOCK           (clk),
      .ARST_N          (arst_n),
      .PSEL            (psel),
      .PENABLE         (penable),
      .PWRITE          (pwrite),
      .PADDR           (paddr),
      .PWDATA          (pwdata),
      .PRDATA          (prdata),
      .PREADY          (pready),
      .PSLVERR         (pslverr),
      .EVENT_INPUT_PIN (pin),
      .HIGH_TOGGLE_OUT (hi_out),
      .LOW_TOGGLE_OUT  (lo_out),
      .HIGH_OVF_IRQ    (hi_irq),
      .LOW_OVF_IRQ     (lo_irq)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         n_fail++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // rates and toggle counts depend on prescaler phase, so a window
   task automatic check_near(input string what, input int lo, input int hi,
                             input logic [7:0] got);
      tests_run++;
      if ((^got === 1'bx) || got < lo || got > hi) begin
         n_fail++;
         $display("BAD %s expected %0d..%0d seen %h", what, lo, hi, got);
      end
   endtask

   // request held until the rising edge that samples pready high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rv = prdata[7:0];
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         n_fail++;
         final_report();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 8'h00);
   endtask

   task automatic toggles(input logic hi, input int cyc, output int t);
      logic last;
      t = 0;
      @(negedge clk);
      last = hi ? hi_out : lo_out;
      repeat (cyc) begin
         @(negedge clk);
         if ((hi ? hi_out : lo_out) !== last) t++;
         last = hi ? hi_out : lo_out;
      end
   endtask

   task automatic t_reset_map();
      rd(DMT_STAT_OFF);
      check_val("status reset", DMT_STAT_RST, rv);
      rd(DMT_CTRL_OFF);
      check_val("control reads zero", 8'h00, rv);
      rd(DMT_HCMP_OFF);
      check_val("high compare reset", DMT_CMP_RST, rv);
      rd(DMT_LCNT_OFF);
      check_val("low counter reset", DMT_CNT_RST, rv);
      check_val("levels reset", 8'h00, {6'h00, hi_out, lo_out});
      wr(8'h1C, 8'h5A);
      check_val("unmapped write error", 8'h01, {7'h00, re});
      rd(8'h1C);
      check_val("unmapped read data", 8'h00, rv);
      wr(DMT_STAT_OFF, DMT_FLAG_MASK);
      rd(DMT_STAT_OFF);
      check_val("flags set by write", 8'h00, rv);
   endtask

   task automatic t_levels();
      for (int i = 0; i < 4; i++) begin
         wr(DMT_CTRL_OFF, {i[1], 3'h0, i[0], 3'h0});
         repeat (2) @(negedge clk);
         check_val("toggle levels", {6'h00, i[1], i[0]}, {6'h00, hi_out, lo_out});
      end
   endtask

   task automatic t_dividers();
      int d;
      for (int c = 0; c < 4; c++) begin
         d = (c == 0) ? 32 : (c == 1) ? 16 : (c == 2) ? 4 : 2;
         wr(DMT_CTRL_OFF, 8'h44 | 8'(c));
         wr(DMT_LCNT_OFF, 8'h00);
         repeat (64) @(posedge clk);
         rd(DMT_LCNT_OFF);
         check_near("low rate", 64 / d, 72 / d + 1, rv);
         wr(DMT_CTRL_OFF, 8'h40 | 8'(c << 4));
         wr(DMT_HCNT_OFF, 8'h00);
         repeat (64) @(posedge clk);
         rd(DMT_HCNT_OFF);
         check_near("high rate", 64 / d, 72 / d + 1, rv);
      end
   endtask

   // bits 5:4 set on purpose: they must not clock the high half here
   task automatic t_cascade();
      wr(DMT_CTRL_OFF, 8'h37);
      wr(DMT_HCNT_OFF, 8'hFF);
      wr(DMT_LCNT_OFF, 8'hF0);
      repeat (40) @(posedge clk);
      rd(DMT_HCNT_OFF);
      check_val("cascade high count", 8'h00, rv);
      rd(DMT_STAT_OFF);
      check_val("cascade status", 8'hCC, rv);
      @(negedge clk);
      check_val("levels after match", 8'h03, {6'h00, hi_out, lo_out});
   endtask

   task automatic t_flags();
      check_val("requests masked", 8'h00, {6'h00, hi_irq, lo_irq});
      wr(DMT_STAT_OFF, 8'hEE);
      repeat (2) @(negedge clk);
      check_val("requests raised", 8'h03, {6'h00, hi_irq, lo_irq});
      rd(DMT_STAT_OFF);
      check_val("enables written", 8'hEE, rv);
      wr(DMT_STAT_OFF, 8'h22);
      rd(DMT_STAT_OFF);
      check_val("flags cleared", 8'h22, rv);
      @(negedge clk);
      check_val("requests dropped", 8'h00, {6'h00, hi_irq, lo_irq});
      repeat (600) @(posedge clk);
      wr(DMT_STAT_OFF, 8'h22);
      rd(DMT_STAT_OFF);
      check_val("flags kept unread", 8'h2E, rv);
      wr(DMT_STAT_OFF, 8'h00);
   endtask

   task automatic t_low_match();
      int t;
      wr(DMT_CTRL_OFF, 8'h47);
      wr(DMT_LCMP_OFF, 8'h05);
      wr(DMT_STAT_OFF, 8'h01);
      wr(DMT_LCNT_OFF, 8'h00);
      toggles(1'b0, 120, t);
      check_near("low toggles", 9, 11, 8'(t));
      rd(DMT_LCNT_OFF);
      check_near("low count bound", 0, 5, rv);
      rd(DMT_STAT_OFF);
      check_val("low match status", 8'h05, rv);
   endtask

   task automatic t_high_match();
      int t;
      wr(DMT_CTRL_OFF, 8'h70);
      wr(DMT_HCMP_OFF, 8'h03);
      rd(DMT_STAT_OFF);
      wr(DMT_STAT_OFF, 8'h10);
      wr(DMT_HCNT_OFF, 8'h00);
      toggles(1'b1, 80, t);
      check_near("high toggles", 9, 11, 8'(t));
      rd(DMT_HCNT_OFF);
      check_near("high count bound", 0, 3, rv);
      rd(DMT_STAT_OFF);
      check_val("high match status", 8'h50, rv);
   endtask

   task automatic t_event();
      pin <= 1'b1;
      wr(DMT_CTRL_OFF, 8'h40);
      wr(DMT_AUX_OFF, 8'h03);
      for (int e = 0; e < 2; e++) begin
         wr(DMT_LCNT_OFF, 8'h00);
         repeat (4 - e) begin
            repeat (3) @(posedge clk);
            pin <= 1'b0;
            repeat (3) @(posedge clk);
            pin <= 1'b1;
         end
         repeat (6) @(posedge clk);
         rd(DMT_LCNT_OFF);
         check_val("event count", 8'(4 - e), rv);
         wr(DMT_AUX_OFF, 8'h02);
      end
   endtask

   initial begin
      arst_n  = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h00000000;
      pin     = 1'b0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      t_reset_map();
      t_levels();
      t_dividers();
      t_cascade();
      t_flags();
      t_low_match();
      t_high_match();
      t_event();
      final_report();
   end
endmodule // dmt_top_bench
`default_nettype wire
